// [dbm_consts.vh]
`ifndef DBM_CONSTS_VH
`define DBM_CONSTS_VH
`define DBM_ADDR_W 5
`define DBM_CNT_INIT 3'h7
`define DBM_REG_D0H 5'h00
`define DBM_REG_D0L 5'h01
`define DBM_REG_D1H 5'h02
`define DBM_REG_D1L 5'h03
`define DBM_REG_CTRL0 5'h05
`define DBM_REG_CTRL1 5'h06
`define DBM_REG_POLY0 5'h08
`define DBM_REG_SEED0 5'h0a
`define DBM_REG_SSCTRL0 5'h0e
`define DBM_REG_SSCTRL1 5'h0f
`define DBM_REG_LEN0 5'h0c
`define DBM_REG_LEN1 5'h0d
`define DBM_FIFO_DEPTH 4
`define DBM_FRAME_GAP 8'h10
`endif

// [dbm_engine.v]
// Contract
// R1: serial machine steps on rising serial clock edges; idle on reset or chip select high.
// R2: entering serial idle clears write flag and loads bit counter with seven.
// R3: first byte is command; its first bit is latched as write flag.
// R4: register pointer loads from last five command bits.
// R5: burst state holds until chip select high or reset.
// R6: writes to control, crc or spread registers raise channel abort.
// R7: writing low data byte pushes transmit queue after data is stored.
// R8: any access to low data byte pops nonempty receive queue.
// R9: receive push happens before transmit pop.
// R10: bus machine steps on third-bit clock; reset, abort, disable force frame-gap wait.
// R11: enabled with queued word drives frame low, waits three third-bit states.
// R12: bit index loads data length plus crc length minus one before first bit.
// R13: each bit low, data, high thirds; index decrements until last crc bit.
// R14: one state for receive push, another for transmit pop, then frame-gap wait.
// R15: frame-gap counter restarts at end of last crc bit.
// R16: transmit queue holds four entries.
// R17: data writes while transmit queue full are ignored with no push.
// R18: host checks transmit room flag before writing another word.
// R19: reset, abort, disable empty the transmit queue and clear pointers.
// R20: push increments push pointer, clears empty, may reach full.
// R21: pop increments pop pointer; last pop sets empty.
// R22: receive queue holds four entries each with a crc error bit.
// R23: push, pop and abort requests cross domains by synchronised handshakes; here all logic runs on one clock and requests are one-clock pulses.
`include "dbm_consts.vh"
module dbm_engine #(
    parameter DATA_W = 16,
    parameter DEPTH = `DBM_FIFO_DEPTH
) (
    input wire clk_i,
    input wire reset_i,
    input wire sclk_i,
    input wire cs_n_i,
    input wire mosi_i,
    input wire bitclk_i,
    input wire enable_i,
    input wire short_word_select_i,
    input wire [3:0] short_word_length_i,
    input wire [3:0] check_length_i,
    input wire resp_bit_i,
    input wire crc_error_i,
    output reg signal_drive_line_o,
    output reg frame_line_o,
    output reg transmit_room_flag_o,
    output reg transmit_empty_o,
    output reg receive_ready_o,
    output reg crc_flag_o,
    output reg [DATA_W-1:0] rx_word_o,
    output reg busy_o
);
    localparam SP_IDLE = 2'h0;
    localparam SP_CMD = 2'h1;
    localparam SP_BURST = 2'h2;
    localparam B_GAP = 3'h0;
    localparam B_START = 3'h1;
    localparam B_BIT = 3'h2;
    localparam B_RPUSH = 3'h3;
    localparam B_XPOP = 3'h4;

    // three-stage samplers for the six link and status pins; a level counts once the last two stages agree
    // both link clocks are oversampled here rather than clocking logic directly:
    // this trades top serial speed for a single clock tree and no crossing of words
    reg [2:0] sclk_s, cs_s, mosi_s, bclk_s, resp_s, crc_s;
    always @(posedge clk_i) begin // R23
        sclk_s <= {sclk_s[1:0], sclk_i};
        cs_s <= {cs_s[1:0], cs_n_i};
        mosi_s <= {mosi_s[1:0], mosi_i};
        bclk_s <= {bclk_s[1:0], bitclk_i};
        resp_s <= {resp_s[1:0], resp_bit_i};
        crc_s <= {crc_s[1:0], crc_error_i};
    end

    reg sclk_q, cs_q, bclk_q, sclk_d, bclk_d, mosi_q, resp_q, crc_q;
    always @(posedge clk_i) begin // R23
        if (sclk_s[1] == sclk_s[2]) sclk_q <= sclk_s[2];
        if (cs_s[1] == cs_s[2]) cs_q <= cs_s[2];
        if (bclk_s[1] == bclk_s[2]) bclk_q <= bclk_s[2];
        if (mosi_s[1] == mosi_s[2]) mosi_q <= mosi_s[2];
        // answer and check status come from the line receiver, not from this clock
        if (resp_s[1] == resp_s[2]) resp_q <= resp_s[2];
        if (crc_s[1] == crc_s[2]) crc_q <= crc_s[2];
        sclk_d <= sclk_q;
        bclk_d <= bclk_q;
    end

    // edges seen one clock after the settled level, so data is always older
    wire sclk_rise = sclk_q & ~sclk_d;
    wire bclk_rise = bclk_q & ~bclk_d;

    reg [1:0] sp_state;
    reg write_flag;
    reg [2:0] bit_cnt;
    reg [7:0] shreg;
    reg [4:0] reg_ptr;
    reg [7:0] hi_byte;
    reg [7:0] ctrl_reg;
    reg push_req, pop_req, abort_req;
    reg [DATA_W-1:0] tx_mem [0:DEPTH-1];
    reg [DATA_W:0] rx_mem [0:DEPTH-1];
    reg [1:0] tx_wp, tx_rp, rx_wp, rx_rp;
    reg tx_full, rx_full, rx_nonempty;
    wire [7:0] next_byte = {shreg[6:0], mosi_q};
    // single-channel engine: abort-raising registers of this channel
    function is_abort_reg;
        input [4:0] a;
        begin
            is_abort_reg = (a == `DBM_REG_CTRL0) ||
                (a == `DBM_REG_POLY0) ||
                (a == `DBM_REG_SEED0) ||
                (a == `DBM_REG_LEN0) ||
                (a == `DBM_REG_SSCTRL0);
        end
    endfunction

    // queue pointers wrap at four entries
    function [1:0] ptr_inc;
        input [1:0] p;
        begin
            ptr_inc = p + 2'h1;
        end
    endfunction

    always @(posedge clk_i) begin
        push_req <= 1'b0;
        pop_req <= 1'b0;
        abort_req <= 1'b0;
        if (reset_i || cs_q) begin
            sp_state <= SP_IDLE; // R1 R5
            write_flag <= 1'b0; // R2
            bit_cnt <= `DBM_CNT_INIT; // R2
            shreg <= 8'h00;
            reg_ptr <= 5'h00;
        end else if (sclk_rise) begin // R1
            shreg <= next_byte;
            bit_cnt <= bit_cnt - 3'h1;
            case (sp_state)
                SP_IDLE: begin
                    write_flag <= mosi_q; // R3
                    sp_state <= SP_CMD;
                end
                SP_CMD: begin
                    if (bit_cnt == 3'h0) begin
                        reg_ptr <= next_byte[4:0]; // R4
                        sp_state <= SP_BURST;
                    end
                end
                SP_BURST: begin // R5
                    if (bit_cnt == 3'h0) begin
                        reg_ptr <= reg_ptr + 5'h01;
                        if (reg_ptr == `DBM_REG_D0L) begin
                            if (rx_nonempty) pop_req <= 1'b1; // R8
                            if (write_flag && !tx_full) begin // R17
                                tx_mem[tx_wp] <= {hi_byte, next_byte};
                                push_req <= 1'b1; // R7
                            end
                        end
                        if (write_flag && reg_ptr == `DBM_REG_D0H) hi_byte <= next_byte;
                        if (write_flag && is_abort_reg(reg_ptr)) begin
                            abort_req <= 1'b1; // R6
                            if (reg_ptr == `DBM_REG_CTRL0) ctrl_reg <= next_byte;
                        end
                    end
                end
                default: sp_state <= SP_IDLE;
            endcase
        end
    end

    // bus engine
    reg [2:0] b_state;
    reg [1:0] phase;
    reg [4:0] bit_index;
    reg [7:0] gap_cnt;
    reg [DATA_W-1:0] rx_shift;
    wire [DATA_W-1:0] cur_word = tx_mem[tx_rp];
    wire [4:0] data_len = short_word_select_i ? 5'h08 : {1'b0, short_word_length_i} + 5'h08;
    wire kill = reset_i || abort_req || !enable_i; // R10 R19
    wire tx_empty = (tx_wp == tx_rp) && !tx_full;
    reg bpush, bpop;
    always @(posedge clk_i) begin
        bpush <= 1'b0;
        bpop <= 1'b0;
        if (kill) begin
            b_state <= B_GAP; // R10
            phase <= 2'h0;
            frame_line_o <= 1'b1;
            signal_drive_line_o <= 1'b1;
            gap_cnt <= 8'h00;
            bit_index <= 5'h00;
        end else if (bclk_rise) begin // R10
            if (gap_cnt != `DBM_FRAME_GAP) gap_cnt <= gap_cnt + 8'h01;
            case (b_state)
                B_GAP: begin
                    if (gap_cnt == `DBM_FRAME_GAP && !tx_empty) begin // R11
                        frame_line_o <= 1'b0;
                        b_state <= B_START;
                        phase <= 2'h0;
                    end
                end
                B_START: begin // R11
                    phase <= phase + 2'h1;
                    if (phase == 2'h2) begin
                        bit_index <= data_len + {1'b0, check_length_i} - 5'h01; // R12
                        phase <= 2'h0;
                        b_state <= B_BIT;
                    end
                end
                B_BIT: begin // R13
                    case (phase)
                        2'h0: signal_drive_line_o <= 1'b0;
                        2'h1: signal_drive_line_o <= (bit_index < DATA_W) ?
                            cur_word[bit_index[3:0]] : 1'b0;
                        default: signal_drive_line_o <= 1'b1;
                    endcase
                    // answer taken at the end of the low third, where the remote has settled
                    if (phase == 2'h1) rx_shift <= {rx_shift[DATA_W-2:0], resp_q};
                    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
                    if (phase == 2'h2) begin
                        if (bit_index == 5'h00) begin
                            gap_cnt <= 8'h00; // R15
                            b_state <= B_RPUSH; // R14
                        end else begin
                            bit_index <= bit_index - 5'h01; // R13
                        end
                    end
                end
                B_RPUSH: begin
                    bpush <= 1'b1; // R9 R14
                    b_state <= B_XPOP;
                end
                B_XPOP: begin
                    bpop <= 1'b1; // R9 R14
                    frame_line_o <= 1'b1;
                    b_state <= B_GAP;
                end
                default: b_state <= B_GAP;
            endcase
        end
    end

    // queues: one clock here, requests already sampled into it // R23
    always @(posedge clk_i) begin
        if (kill) begin
            tx_wp <= 2'h0; // R19
            tx_rp <= 2'h0;
            tx_full <= 1'b0;
            rx_wp <= 2'h0;
            rx_rp <= 2'h0;
            rx_full <= 1'b0;
            rx_nonempty <= 1'b0;
        end else begin
            if (push_req) tx_wp <= ptr_inc(tx_wp); // R16 R20
            if (bpop) tx_rp <= ptr_inc(tx_rp); // R21
            // a push and a pop together leave the fill level unchanged
            if (push_req && !bpop && (ptr_inc(tx_wp) == tx_rp)) tx_full <= 1'b1; // R20
            else if (bpop && !push_req) tx_full <= 1'b0; // R21
            if (bpush) begin
                // check status stored beside its word so both leave together
                rx_mem[rx_wp] <= {crc_q, rx_shift}; // R22
                rx_wp <= ptr_inc(rx_wp);
            end
            if (pop_req) rx_rp <= ptr_inc(rx_rp);
            if (bpush && !pop_req) begin
                rx_nonempty <= 1'b1;
                if (ptr_inc(rx_wp) == rx_rp) rx_full <= 1'b1; // R22
            end else if (pop_req && !bpush) begin
                rx_full <= 1'b0;
                if (ptr_inc(rx_rp) == rx_wp && !rx_full) rx_nonempty <= 1'b0;
            end
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            transmit_room_flag_o <= 1'b1;
            transmit_empty_o <= 1'b1;
            receive_ready_o <= 1'b0;
            crc_flag_o <= 1'b0;
            rx_word_o <= {DATA_W{1'b0}};
            busy_o <= 1'b0;
        end else begin
            transmit_room_flag_o <= !tx_full;
            transmit_empty_o <= tx_empty;
            receive_ready_o <= rx_nonempty;
            crc_flag_o <= rx_nonempty & rx_mem[rx_rp][DATA_W];
            rx_word_o <= rx_mem[rx_rp][DATA_W-1:0];
            busy_o <= (b_state != B_GAP);
        end
    end
endmodule

// [dbm_engine_assertions.sv]
module dbm_engine_chk (
    input wire clk_i,
    input wire reset_i,
    input wire enable_i,
    input wire signal_drive_line_o,
    input wire frame_line_o,
    input wire transmit_room_flag_o,
    input wire transmit_empty_o,
    input wire receive_ready_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    property p_rst; $fell(reset_i) |-> transmit_empty_o && frame_line_o && !receive_ready_o; endproperty
    a_rst: assert property (p_rst) else $error("bad state after reset");
    property p_dis; $fell(enable_i) |-> ##[1:4] transmit_empty_o; endproperty
    a_dis: assert property (p_dis) else $error("disable left queue filled");
    property p_full; !transmit_room_flag_o |-> !transmit_empty_o; endproperty
    a_full: assert property (p_full) else $error("full and empty together");
    property p_sig; $fell(signal_drive_line_o) |-> !frame_line_o; endproperty
    a_sig: assert property (p_sig) else $error("signal low outside frame");
    property p_start; $fell(frame_line_o) |-> !transmit_empty_o && $past(enable_i); endproperty
    a_start: assert property (p_start) else $error("frame without queued word");
    property p_lead; $fell(frame_line_o) |-> signal_drive_line_o [*8]; endproperty
    a_lead: assert property (p_lead) else $error("no start delay");
    property p_order; $rose(receive_ready_o) |-> !$past(transmit_empty_o); endproperty
    a_order: assert property (p_order) else $error("pop before push");
    property p_gap; $rose(frame_line_o) |-> frame_line_o [*8]; endproperty
    a_gap: assert property (p_gap) else $error("frame gap too short");
endmodule
bind dbm_engine dbm_engine_chk dbm_engine_chk_i (.clk_i(clk_i), .reset_i(reset_i),
    .enable_i(enable_i), .signal_drive_line_o(signal_drive_line_o),
    .frame_line_o(frame_line_o), .transmit_room_flag_o(transmit_room_flag_o),
    .transmit_empty_o(transmit_empty_o), .receive_ready_o(receive_ready_o));

// [dbm_node.sv]
module dbm_node #(
    parameter logic [15:0] PAT = 16'h5a3c
) (
    input wire frame_i,
    input wire sig_i,
    output logic resp_o,
    output logic err_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] n = 4'h0;
    logic [4:0] k = 5'h0;
    always @(negedge frame_i) n <= n + 4'h1;
    // each bit opens with a falling edge, so k tracks the bit number
    always @(negedge frame_i or negedge sig_i) k <= sig_i ? 5'h0 : k + 5'h1;
    // odd frames answer inverted with a check error, so entries differ
    assign resp_o = frame_i ? ~sig_i : PAT[5'h10 - k] ^ n[0];
    assign err_o = n[0];
endmodule

// [test_dbm_engine.sv]
module test_dbm_engine;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] PAT = 16'h5a3c;
    logic clk_i = 1'b0, reset_i = 1'b1, sclk = 1'b1, cs_n = 1'b1, mosi = 1'b0;
    logic bitclk = 1'b0, en = 1'b0;
    wire resp, err, sig, frame, room, empty, ready, crc, busy;
    wire [15:0] rx;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    always #2.5 clk_i = ~clk_i;
    always #62.5 bitclk = ~bitclk;
    dbm_engine dbm_engine_i (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .mosi_i(mosi), .bitclk_i(bitclk), .enable_i(en), .short_word_select_i(1'b0),
        .short_word_length_i(4'h8), .check_length_i(4'h0), .resp_bit_i(resp),
        .crc_error_i(err), .signal_drive_line_o(sig), .frame_line_o(frame),
        .transmit_room_flag_o(room), .transmit_empty_o(empty), .receive_ready_o(ready),
        .crc_flag_o(crc), .rx_word_o(rx), .busy_o(busy));
    dbm_node #(.PAT(PAT)) dbm_node_i (.frame_i(frame), .sig_i(sig), .resp_o(resp),
        .err_o(err));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic put(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sclk <= 1'b0;
            mosi <= b[i];
            tick(4);
            sclk <= 1'b1;
            tick(4);
        end
    endtask
    task automatic xfer(input logic [7:0] c, input logic [7:0] b0, input logic [7:0] b1);
        cs_n <= 1'b0;
        tick(4);
        put(c);
        put(b0);
        if (c[7] && c[4:0] == 5'h00) put(b1);
        tick(4);
        cs_n <= 1'b1;
        tick(8);
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        tick(20);
        reset_i <= 1'b0;
        en <= 1'b1;
        tick(6);
        chk("idle flags", 16'h001e, {11'h0, frame, sig, room, empty, ready});
        $display("test reset done");
        for (int i = 0; i < 4; i++) xfer(8'h80, {4'h1, 4'(i)}, {4'h2, 4'(i)});
        chk("full flags", 16'h0000, {14'h0, room, empty});
        xfer(8'h80, 8'hee, 8'hee);
        chk("still full", 16'h0000, {14'h0, room, empty});
        for (int i = 0; i < 12000 && empty !== 1'b1; i++) tick(1);
        chk("queue drained", 16'h0003, {14'h0, room, empty});
        for (int i = 0; i < 4; i++) begin
            chk("rx ready", 16'h0001, {15'h0, ready});
            chk("rx word", i[0] ? PAT : ~PAT, rx);
            chk("crc flag", {15'h0, ~i[0]}, {15'h0, crc});
            xfer(8'h01, 8'h00, 8'h00);
        end
        chk("rx emptied", 16'h0000, {15'h0, ready});
        $display("test queues done");
        xfer(8'h80, 8'h12, 8'h34);
        tick(200);
        chk("frame running", 16'h0001, {14'h0, frame, busy});
        xfer(8'h85, 8'h00, 8'h00);
        chk("abort", 16'h000c, {12'h0, frame, empty, ready, busy});
        $display("test abort done");
        xfer(8'h80, 8'h56, 8'h78);
        tick(200);
        en <= 1'b0;
        tick(4);
        chk("disable", 16'h000c, {12'h0, frame, empty, ready, busy});
        $display("test disable done");
        print_verdict();
    end
endmodule
